// >>> hw/dbgp_pkg.sv
// Purpose: shared types and constants of the debug pin front end
// Assumes: 50 MHz system clock
// Notes: no software registers
package dbgp_pkg;

  // ****************************************
  // constants
  // ****************************************
  localparam int unsigned clk_period_ns = 20;
  localparam int unsigned strap_low_min_cycles = 2;
  localparam int unsigned tap_ir_width = 4;
  localparam logic [3:0] ir_reset_val = 4'hf;
  localparam logic [3:0] ir_bypass = 4'hf;
  localparam logic [3:0] ir_trigger = 4'h2;
  localparam int unsigned trig_pulse_cycles = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    dbgp_tlr = 4'h0, dbgp_rti = 4'h1, dbgp_sel_dr = 4'h2, dbgp_cap_dr = 4'h3,
    dbgp_sh_dr = 4'h4, dbgp_ex1_dr = 4'h5, dbgp_pa_dr = 4'h6, dbgp_ex2_dr = 4'h7,
    dbgp_up_dr = 4'h8, dbgp_sel_ir = 4'h9, dbgp_cap_ir = 4'ha, dbgp_sh_ir = 4'hb,
    dbgp_ex1_ir = 4'hc, dbgp_pa_ir = 4'hd, dbgp_ex2_ir = 4'he, dbgp_up_ir = 4'hf
  } dbgp_tap_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } dbgp_pins_type;

  typedef struct packed {
    logic [23:0] addr_lo;
    logic [23:0] addr_hi;
    logic [7:0] data_val;
    logic [7:0] data_mask;
    logic use_data;
    logic fire_trig;
    logic start_trace;
    logic stop_trace;
  } dbgp_bp_type;

endpackage

// >>> hw/dbgp_bp_match.sv
// Purpose: breakpoint compare of bus activity against a range and masked data
// Assumes: bus sample from the same clock
// Notes: one-cycle registered result
`timescale 1ns/10ps
module dbgp_bp_match (
  input wire logic clk,
  input wire logic resetn,
  input wire dbgp_pkg::dbgp_bp_type cfg,
  input wire logic bus_valid,
  input wire logic [23:0] bus_addr,
  input wire logic [7:0] bus_data,
  output logic hit,
  output logic trace_on
);

  typedef struct packed {
    logic hit;
    logic trace_on;
  } dbgp_bps_type;

  dbgp_bps_type s_q, s_d;

  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    logic m;
    m = 1'b0;
    s_d = s_q;
    // two addresses bound the range, data compared under mask
    m = bus_valid && in_range(bus_addr, cfg.addr_lo, cfg.addr_hi) &&
        (!cfg.use_data || ((bus_data & cfg.data_mask) == (cfg.data_val & cfg.data_mask)));
    s_d.hit = m && cfg.fire_trig;
    if (m && cfg.start_trace) begin
      s_d.trace_on = 1'b1;
    end else if (m && cfg.stop_trace) begin
      s_d.trace_on = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hit = s_q.hit;
  assign trace_on = s_q.trace_on;

  range_hit_a: assert property (@(posedge clk) disable iff (!resetn)
    (bus_valid && cfg.fire_trig && !cfg.use_data && bus_addr >= cfg.addr_lo && bus_addr <= cfg.addr_hi) |=> hit)
    else $error("range hit not flagged");

endmodule

// >>> hw/dbgp_front.sv
// Purpose: pin front end of the debug unit: mode strap, tap, two-wire pins, trigger
// Assumes: test clock period at least two system clocks, sampled by clk
// Notes: test clock edges found by oversampling, so edges act two to three clocks late
`timescale 1ns/10ps
module dbgp_front #(
  parameter int unsigned pulse_cycles = dbgp_pkg::trig_pulse_cycles
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdi_out,
  output logic tdi_oe_n,
  output logic tdo,
  output logic trig_out,
  output logic trig_oe_n,
  input wire dbgp_pkg::dbgp_bp_type bp_cfg,
  input wire logic bus_valid,
  input wire logic [23:0] bus_addr,
  input wire logic [7:0] bus_data,
  input wire logic zw_data_out,
  input wire logic zw_data_drive,
  output logic full_unit_en,
  output logic two_wire_en,
  output logic zw_clk_rise,
  output logic zw_clk_fall,
  output logic zw_data_in,
  output logic trace_on,
  output logic [3:0] tap_ir
);

  // the counter is eight bits wide, so longer pulses cannot be served
  if (pulse_cycles < 1 || pulse_cycles > 255) begin : gen_bad_pulse
    $error("pulse_cycles out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dbgp_pkg::dbgp_pins_type s1;
    dbgp_pkg::dbgp_pins_type s2;
    logic tck_prev;
    logic in_reset;
    logic full_en;
    logic [3:0] tap;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic dr_sh;
    logic tdo;
    logic [7:0] trig_cnt;
  } dbgp_st_type;

  dbgp_st_type s_q, s_d;
  logic bp_hit;
  logic rise;
  logic fall;

  dbgp_bp_match dbgp_bp_match_inst (
    .clk(clk),
    .resetn(resetn),
    .cfg(bp_cfg),
    .bus_valid(bus_valid && s_q.full_en),
    .bus_addr(bus_addr),
    .bus_data(bus_data),
    .hit(bp_hit),
    .trace_on(trace_on)
  );

  function automatic logic [3:0] tap_next(input logic [3:0] st, input logic tms);
    case (dbgp_pkg::dbgp_tap_type'(st))
      dbgp_pkg::dbgp_tlr: tap_next = tms ? 4'h0 : 4'h1;
      dbgp_pkg::dbgp_rti: tap_next = tms ? 4'h2 : 4'h1;
      dbgp_pkg::dbgp_sel_dr: tap_next = tms ? 4'h9 : 4'h3;
      dbgp_pkg::dbgp_cap_dr: tap_next = tms ? 4'h5 : 4'h4;
      dbgp_pkg::dbgp_sh_dr: tap_next = tms ? 4'h5 : 4'h4;
      dbgp_pkg::dbgp_ex1_dr: tap_next = tms ? 4'h8 : 4'h6;
      dbgp_pkg::dbgp_pa_dr: tap_next = tms ? 4'h7 : 4'h6;
      dbgp_pkg::dbgp_ex2_dr: tap_next = tms ? 4'h8 : 4'h4;
      dbgp_pkg::dbgp_up_dr: tap_next = tms ? 4'h2 : 4'h1;
      dbgp_pkg::dbgp_sel_ir: tap_next = tms ? 4'h0 : 4'ha;
      dbgp_pkg::dbgp_cap_ir: tap_next = tms ? 4'hc : 4'hb;
      dbgp_pkg::dbgp_sh_ir: tap_next = tms ? 4'hc : 4'hb;
      dbgp_pkg::dbgp_ex1_ir: tap_next = tms ? 4'hf : 4'hd;
      dbgp_pkg::dbgp_pa_ir: tap_next = tms ? 4'he : 4'hd;
      dbgp_pkg::dbgp_ex2_ir: tap_next = tms ? 4'hf : 4'hb;
      dbgp_pkg::dbgp_up_ir: tap_next = tms ? 4'h2 : 4'h1;
      default: tap_next = 4'h0;
    endcase
  endfunction

  // pins arrive already resolved; pull-ups make a floating pin read one
  assign rise = s_q.s2.tck && !s_q.tck_prev;
  assign fall = !s_q.s2.tck && s_q.tck_prev;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.s1 = '{tck: tck_in, tms: tms_in, tdi: tdi_in};
    s_d.s2 = s_q.s1;
    s_d.tck_prev = s_q.s2.tck;
    s_d.in_reset = 1'b0;
    // strap lands on the first clock after release, then is frozen
    if (s_q.in_reset) begin
      s_d.full_en = !s_q.s2.tck;
    end
    if (s_q.full_en && rise) begin
      s_d.tap = tap_next(s_q.tap, s_q.s2.tms);
      case (dbgp_pkg::dbgp_tap_type'(s_q.tap))
        dbgp_pkg::dbgp_tlr: s_d.ir = dbgp_pkg::ir_reset_val;
        dbgp_pkg::dbgp_cap_ir: s_d.ir_sh = 4'h1;
        dbgp_pkg::dbgp_sh_ir: s_d.ir_sh = {s_q.s2.tdi, s_q.ir_sh[3:1]};
        dbgp_pkg::dbgp_up_ir: s_d.ir = s_q.ir_sh;
        dbgp_pkg::dbgp_cap_dr: s_d.dr_sh = 1'b0;
        dbgp_pkg::dbgp_sh_dr: s_d.dr_sh = s_q.s2.tdi;
        default: s_d.ir = s_q.ir;
      endcase
    end
    if (s_q.full_en && fall) begin
      case (dbgp_pkg::dbgp_tap_type'(s_q.tap))
        dbgp_pkg::dbgp_sh_ir: s_d.tdo = s_q.ir_sh[0];
        dbgp_pkg::dbgp_sh_dr: s_d.tdo = s_q.dr_sh;
        default: s_d.tdo = s_q.tdo;
      endcase
    end
    // trigger: a breakpoint hit or a test clock rise in update-dr with the trigger instruction loaded
    if (s_q.trig_cnt != 8'h00) begin
      s_d.trig_cnt = s_q.trig_cnt - 8'h01;
    end else if (s_q.full_en && (bp_hit || (rise && s_q.ir == dbgp_pkg::ir_trigger &&
                 s_q.tap == 4'h8))) begin
      s_d.trig_cnt = 8'(pulse_cycles);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      // synchronisers keep running so the strap sees the pin during reset
      s_q <= '{s1: s_d.s1, s2: s_d.s2, tck_prev: s_d.tck_prev, in_reset: 1'b1, full_en: 1'b0,
               tap: 4'h0, ir: dbgp_pkg::ir_reset_val, ir_sh: 4'h0, dr_sh: 1'b0,
               tdo: 1'b0, trig_cnt: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign full_unit_en = s_q.full_en;
  assign two_wire_en = !s_q.full_en && !s_q.in_reset;
  assign zw_clk_rise = two_wire_en && rise;
  assign zw_clk_fall = two_wire_en && fall;
  assign zw_data_in = s_q.s2.tdi;
  assign tdi_out = zw_data_out;
  // input-only while the full unit owns the pin
  assign tdi_oe_n = !(two_wire_en && zw_data_drive);
  assign tdo = s_q.tdo;
  assign trig_out = s_q.trig_cnt != 8'h00;
  assign trig_oe_n = s_q.trig_cnt == 8'h00;
  assign tap_ir = s_q.ir;

  // ****************************************
  // checks
  // ****************************************
  mode_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !s_q.in_reset |=> $stable(full_unit_en))
    else $error("debug mode changed after reset");
  strap_low_a: assert property (@(posedge clk)
    (!resetn ##1 resetn && !s_q.s2.tck && s_q.in_reset) |=> full_unit_en)
    else $error("low strap did not enable full unit");
  strap_high_a: assert property (@(posedge clk)
    (resetn && s_q.s2.tck && s_q.in_reset) |=> two_wire_en)
    else $error("high strap did not pick two-wire mode");
  tdo_fall_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(s_q.tdo) |-> $past(fall))
    else $error("data out moved off a falling edge");
  tdi_input_a: assert property (@(posedge clk) disable iff (!resetn)
    full_unit_en |-> tdi_oe_n)
    else $error("data-in driven in full mode");
  tap_step_a: assert property (@(posedge clk) disable iff (!resetn)
    (full_unit_en && rise && s_q.tap == 4'h0 && !s_q.s2.tms) |=> s_q.tap == 4'h1)
    else $error("tap did not leave reset on low select");
  trig_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    ($rose(trig_out) && pulse_cycles > 1) |-> !trig_oe_n ##1 trig_out)
    else $error("trigger pulse malformed");
  trig_float_a: assert property (@(posedge clk) disable iff (!resetn)
    !trig_out |-> trig_oe_n)
    else $error("trigger driven while idle");
  zw_clk_a: assert property (@(posedge clk) disable iff (!resetn)
    zw_clk_rise |-> two_wire_en && !full_unit_en)
    else $error("two-wire clock in full mode");
  cov_full_c: cover property (@(posedge clk) disable iff (!resetn) $rose(full_unit_en));
  cov_two_c: cover property (@(posedge clk) disable iff (!resetn) zw_clk_rise);
  cov_trig_c: cover property (@(posedge clk) disable iff (!resetn) $rose(trig_out));

endmodule

// >>> verification/dbgp_probe.sv
// Purpose: behavioural debug probe on the far side of the test pins
// Assumes: pull-ups on every test pin
// Notes: tck stands still between frames
`timescale 1ns/10ps
module dbgp_probe (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic tdi_drive
);
  logic tck_drive;
  logic tck_val;
  // a released pin floats up to one
  assign tck = tck_drive ? tck_val : 1'b1;
  initial begin
    tck_drive = 1'b0;
    tck_val = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
    tdi_drive = 1'b0;
  end
  // held low across reset release selects the full unit
  task strap(input logic low);
    tck_drive = low;
    tck_val = 1'b0;
  endtask
  // 160 ns period, at least two system clocks, no phase tie to clk
  task clock_bit(input logic m, input logic d);
    tck_drive = 1'b1;
    tck_val = 1'b0;
    tms = m;
    tdi = d;
    tdi_drive = 1'b1;
    #80;
    tck_val = 1'b1;
    #80;
  endtask
  task release_pins();
    tck_drive = 1'b0;
    tdi_drive = 1'b0;
    tms = 1'b1;
  endtask
endmodule

// >>> verification/dbgp_front_tb.sv
// Purpose: self-checking bench of the debug pin front end
// Assumes: 50 MHz clk, inputs driven on falling edges
// Notes: tdi pin resolved here from both drivers and the pull-up
`timescale 1ns/10ps
module dbgp_front_tb;
  // ****************************************
  // bench
  // ****************************************
  logic clk, resetn, tck, tms, ptdi, pdrv, tdi_pin, tdi_out, tdi_oe_n, tdo, trig_out, trig_oe_n;
  logic bus_valid, zw_data_out, zw_data_drive, full_unit_en, two_wire_en, zw_clk_rise, zw_clk_fall;
  logic zw_data_in, trace_on;
  logic [23:0] bus_addr;
  logic [7:0] bus_data;
  logic [3:0] tap_ir;
  dbgp_pkg::dbgp_bp_type bp_cfg;
  int fail_count, check_count;
  assign tdi_pin = !tdi_oe_n ? tdi_out : (pdrv ? ptdi : 1'b1);
  dbgp_probe dbgp_probe_inst (.tck(tck), .tms(tms), .tdi(ptdi), .tdi_drive(pdrv));
  dbgp_front #(.pulse_cycles(dbgp_pkg::trig_pulse_cycles)) dbgp_front_inst (.clk(clk), .resetn(resetn),
    .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi_pin), .tdi_out(tdi_out), .tdi_oe_n(tdi_oe_n), .tdo(tdo), .trig_out(trig_out),
    .trig_oe_n(trig_oe_n), .bp_cfg(bp_cfg), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data),
    .zw_data_out(zw_data_out), .zw_data_drive(zw_data_drive), .full_unit_en(full_unit_en),
    .two_wire_en(two_wire_en), .zw_clk_rise(zw_clk_rise), .zw_clk_fall(zw_clk_fall),
    .zw_data_in(zw_data_in), .trace_on(trace_on), .tap_ir(tap_ir));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task check(input logic [3:0] got, input logic [3:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task do_reset(input logic strap_low);
    dbgp_probe_inst.strap(strap_low);
    resetn = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // one observed bus cycle, then count trigger cycles; pin must be released whenever low
  task bus_hit(input logic [23:0] a, input logic [7:0] d, input int exp_n);
    int n;
    n = 0;
    bus_valid = 1'b1;
    bus_addr = a;
    bus_data = d;
    @(negedge clk);
    bus_valid = 1'b0;
    repeat (12) begin
      @(negedge clk);
      if (trig_out === 1'b1) n++;
      check(trig_oe_n, !trig_out, "trigger enable");
    end
    check(n[3:0], exp_n[3:0], "trigger length");
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task test_full();
    int n;
    n = 0;
    do_reset(1'b1);
    check(full_unit_en, 1'b1, "full unit");
    check(two_wire_en, 1'b0, "two wire");
    // run-test, select-dr, select-ir, capture-ir, shift-ir, four bits lsb first, update, idle
    dbgp_probe_inst.clock_bit(1'b0, 1'b1);
    dbgp_probe_inst.clock_bit(1'b1, 1'b1);
    dbgp_probe_inst.clock_bit(1'b1, 1'b1);
    dbgp_probe_inst.clock_bit(1'b0, 1'b1);
    dbgp_probe_inst.clock_bit(1'b0, 1'b1);
    dbgp_probe_inst.clock_bit(1'b0, 1'b0);
    dbgp_probe_inst.clock_bit(1'b0, 1'b1);
    dbgp_probe_inst.clock_bit(1'b0, 1'b0);
    dbgp_probe_inst.clock_bit(1'b1, 1'b0);
    dbgp_probe_inst.clock_bit(1'b1, 1'b1);
    dbgp_probe_inst.clock_bit(1'b0, 1'b1);
    dbgp_probe_inst.release_pins();
    repeat (8) @(negedge clk);
    check(tap_ir, dbgp_pkg::ir_trigger, "instruction");
    check(tdi_oe_n, 1'b1, "data-in input only");
    check(full_unit_en, 1'b1, "mode held");
    // select-dr, capture-dr, shift a one through bypass, exit, update, leave update to fire
    dbgp_probe_inst.clock_bit(1'b1, 1'b1);
    dbgp_probe_inst.clock_bit(1'b0, 1'b1);
    dbgp_probe_inst.clock_bit(1'b0, 1'b1);
    dbgp_probe_inst.clock_bit(1'b0, 1'b1);
    dbgp_probe_inst.clock_bit(1'b1, 1'b0);
    dbgp_probe_inst.clock_bit(1'b1, 1'b0);
    fork
      dbgp_probe_inst.clock_bit(1'b0, 1'b0);
      repeat (16) begin
        @(negedge clk);
        if (trig_out === 1'b1) n++;
      end
    join
    dbgp_probe_inst.release_pins();
    check(tdo, 1'b1, "bypass data out");
    check(n[3:0], dbgp_pkg::trig_pulse_cycles, "instruction trigger");
    bus_hit(24'h001000, 8'h5a, dbgp_pkg::trig_pulse_cycles);
    check(trace_on, 1'b1, "trace started");
    bus_hit(24'h001fff, 8'h53, dbgp_pkg::trig_pulse_cycles);
    bus_hit(24'h002000, 8'h5a, 0);
    bus_hit(24'h001800, 8'h6a, 0);
    bp_cfg.start_trace = 1'b0;
    bp_cfg.stop_trace = 1'b1;
    bus_hit(24'h001000, 8'h5a, dbgp_pkg::trig_pulse_cycles);
    check(trace_on, 1'b0, "trace stopped");
    $display("test_full done");
  endtask
  task test_two_wire();
    int r, f;
    r = 0;
    f = 0;
    dbgp_probe_inst.release_pins();
    do_reset(1'b0);
    check(two_wire_en, 1'b1, "two wire");
    check(full_unit_en, 1'b0, "full unit off");
    zw_data_drive = 1'b1;
    zw_data_out = 1'b0;
    @(negedge clk);
    check({tdi_oe_n, tdi_out}, 2'b00, "serial data drive low");
    zw_data_out = 1'b1;
    @(negedge clk);
    check({tdi_oe_n, tdi_out}, 2'b01, "serial data drive high");
    zw_data_drive = 1'b0;
    fork
      dbgp_probe_inst.clock_bit(1'b1, 1'b0);
      repeat (14) begin
        @(negedge clk);
        r += zw_clk_rise;
        f += zw_clk_fall;
      end
    join
    check(tdi_oe_n, 1'b1, "serial data released");
    check(zw_data_in, 1'b0, "serial data in");
    check({r[1:0], f[1:0]}, 4'h5, "serial clock edges");
    dbgp_probe_inst.release_pins();
    bus_hit(24'h001000, 8'h5a, 0);
    check(two_wire_en, 1'b1, "mode held");
    check(zw_data_in, 1'b1, "released data pulled up");
    $display("test_two_wire done");
  endtask
  initial begin
    fail_count = 0;
    check_count = 0;
    resetn = 1'b0;
    bus_valid = 1'b0;
    bus_addr = 24'h000000;
    bus_data = 8'h00;
    zw_data_out = 1'b0;
    zw_data_drive = 1'b0;
    bp_cfg = '{addr_lo: 24'h001000, addr_hi: 24'h001fff, data_val: 8'h5a, data_mask: 8'hf0,
      use_data: 1'b1, fire_trig: 1'b1, start_trace: 1'b1, stop_trace: 1'b0};
    test_full();
    test_two_wire();
    stop_test();
  end
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule
